// ---- rtl/smb_pkg.sv ----
package smb_pkg;
    // Bus addresses.
    localparam logic [6:0] DEV_ADDR_STD = 7'h4C;
    localparam logic [6:0] DEV_ADDR_ALT = 7'h4D;
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    // Register read offsets.
    localparam logic [7:0] RD_LOCAL = 8'h00;
    localparam logic [7:0] RD_REMOTE = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CFG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_LHI = 8'h05;
    localparam logic [7:0] RD_LLO = 8'h06;
    localparam logic [7:0] RD_RHI = 8'h07;
    localparam logic [7:0] RD_RLO = 8'h08;
    // Register write offsets.
    localparam logic [7:0] WR_CFG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0A;
    localparam logic [7:0] WR_LHI = 8'h0B;
    localparam logic [7:0] WR_LLO = 8'h0C;
    localparam logic [7:0] WR_RHI = 8'h0D;
    localparam logic [7:0] WR_RLO = 8'h0E;
    localparam logic [7:0] ONE_SHOT_TRIGGER = 8'h0F;
    localparam logic [7:0] ALERT_FILTER_AND_BUS_TIMEOUT = 8'h22;
    // Values after reset.
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h08;
    localparam logic [7:0] RST_HI = 8'h55;
    localparam logic [7:0] RST_LO = 8'h00;
    localparam logic [7:0] RST_FILTER = 8'h01;
    // Field positions.
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_THERM2_BIT = 5;
    localparam int TOUT_EN_BIT = 7;
    // Positions in the vector of inputs synchronised into the core clock.
    localparam int SY_SCL = 7;
    localparam int SY_SDA = 6;
    localparam int SY_START = 5;
    localparam int SY_STOP = 4;
    localparam int SY_PTR = 3;
    localparam int SY_DAT = 2;
    localparam int SY_RD = 1;
    localparam int SY_ARA = 0;
    // Bus inactivity timeout.
    localparam int CLK_HZ = 50_000_000;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int TOUT_W = 21;
    // Byte phases of the serial link.
    typedef enum logic [1:0] {SMB_IDLE, SMB_ADDR, SMB_WR, SMB_RD} smb_phase_e;
endpackage

// ---- rtl/smb_slave.sv ----
// Operation
// - Inactive bus times out after 25 ms.
// - Timeout enabled only by filter register bit 7.
// - Answer fixed address 0x4C or 0x4D.
// - Start is data falling while clock high.
// - Shift seven address bits then direction.
// - Matched address acknowledged on ninth clock.
// - Each byte is eight bits plus acknowledge.
// - Data changes only in clock low; rise is stop.
// - Writes carry one or two bytes, reads one.
// - First written byte loads address pointer.
// - Second written byte goes to pointed register.
// - Reads return register at retained pointer.
// - Separate read and write offsets kept apart.
// - Alert pulls low on limit or open fault.
// - Alert response read returns own address.
// - Arbitration loss withdraws from alert response.
// - Alert released after response if fault gone.
// - Standby bit stops and aborts conversions.
// - One-shot write in standby runs one conversion.
// - Limit writes in standby recheck stored values.
// - Alert clears only after status read too.
`timescale 1ns/10ps

module smb_link #(
    parameter logic [6:0] DEV_ADDR = smb_pkg::DEV_ADDR_STD
) (
    input wire logic scl_clk,
    input wire logic reset,
    input wire logic abort,
    input wire logic sda_in,
    input wire logic alert_on,
    input wire logic [7:0] rd_word,
    output logic sda_oe,
    output logic start_tog,
    output logic stop_tog,
    output logic ptr_tog,
    output logic dat_tog,
    output logic rd_tog,
    output logic ara_tog,
    output logic [7:0] ptr_byte,
    output logic [7:0] dat_byte
);
    import smb_pkg::*;

    typedef struct packed {
        smb_phase_e phase;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] tx;
        logic ack;
        logic rw;
        logic ara;
        logic [1:0] nwr;
        logic [7:0] ptr;
        logic [7:0] dat;
        logic ptr_tog;
        logic dat_tog;
        logic rd_tog;
        logic ara_tog;
        logic [7:0] rd_meta;
        logic [7:0] rd_sync;
        logic al_meta;
        logic al_sync;
    } smb_link_s;

    smb_link_s q, d;
    logic start_q, stop_q, start_seen_q, oe_q, lrst, pend, drv;
    logic [7:0] byte_in;

    // A timeout must free the link even though the serial clock is stalled,
    // so it acts as an asynchronous reset of the link state.
    assign lrst = reset | abort;

    always_ff @(negedge sda_in or posedge reset)
    begin
        if (reset)
            start_q <= 1'b0;
        else if (scl_clk)
            start_q <= ~start_q;
    end

    always_ff @(posedge sda_in or posedge reset)
    begin
        if (reset)
            stop_q <= 1'b0;
        else if (scl_clk)
            stop_q <= ~stop_q;
    end

    // The start toggle settles half a clock before the first address edge,
    // so the link clock may compare it directly.
    always_ff @(posedge scl_clk or posedge reset)
    begin
        if (reset)
            start_seen_q <= 1'b0;
        else
            start_seen_q <= start_q;
    end

    // Byte sequencing on the rising serial clock edge.
    always_comb
    begin
        d = q;
        byte_in = {q.sh[6:0], sda_in};
        pend = start_q ^ start_seen_q;
        d.rd_meta = rd_word;
        d.rd_sync = q.rd_meta;
        d.al_meta = alert_on;
        d.al_sync = q.al_meta;
        if (pend)
        begin
            d.phase = SMB_ADDR;
            d.bits = 4'h1;
            d.sh = {7'h00, sda_in};
            d.ack = 1'b0;
            d.nwr = 2'h0;
            d.ara = 1'b0;
        end
        else
        begin
            case (q.phase)
                SMB_ADDR:
                begin
                    if (q.bits == 4'h7)
                    begin
                        d.sh = byte_in;
                        d.bits = 4'h8;
                        if (byte_in[7:1] == DEV_ADDR)
                        begin
                            d.ack = 1'b1;
                            d.rw = byte_in[0];
                        end
                        else if (byte_in[7:1] == ARA_ADDR && byte_in[0] && q.al_sync)
                        begin
                            d.ack = 1'b1;
                            d.rw = 1'b1;
                            d.ara = 1'b1;
                        end
                        else
                            d.phase = SMB_IDLE;
                    end
                    else if (q.bits == 4'h8)
                    begin
                        d.bits = 4'h0;
                        d.ack = 1'b0;
                        d.phase = q.rw ? SMB_RD : SMB_WR;
                        if (q.rw)
                        begin
                            d.tx = q.ara ? {DEV_ADDR, 1'b1} : q.rd_sync;
                            d.rd_tog = q.ara ? q.rd_tog : ~q.rd_tog;
                        end
                    end
                    else
                    begin
                        d.sh = byte_in;
                        d.bits = 4'(q.bits + 4'h1);
                    end
                end
                SMB_WR:
                begin
                    if (q.bits == 4'h7)
                    begin
                        d.sh = byte_in;
                        d.bits = 4'h8;
                        d.ack = (q.nwr != 2'h2) && (q.nwr != 2'h3);
                        if (q.nwr == 2'h0)
                        begin
                            d.ptr = byte_in;
                            d.ptr_tog = ~q.ptr_tog;
                        end
                        else if (q.nwr == 2'h1)
                        begin
                            d.dat = byte_in;
                            d.dat_tog = ~q.dat_tog;
                        end
                    end
                    else if (q.bits == 4'h8)
                    begin
                        d.bits = 4'h0;
                        d.ack = 1'b0;
                        if (q.nwr != 2'h3)
                            d.nwr = 2'(q.nwr + 2'h1);
                    end
                    else
                    begin
                        d.sh = byte_in;
                        d.bits = 4'(q.bits + 4'h1);
                    end
                end
                SMB_RD:
                begin
                    if (q.bits == 4'h8)
                    begin
                        d.phase = SMB_IDLE;
                        d.bits = 4'h0;
                        if (q.ara)
                            d.ara_tog = ~q.ara_tog;
                    end
                    else if (q.tx[7] && !sda_in)
                        d.phase = SMB_IDLE;
                    else
                    begin
                        d.tx = {q.tx[6:0], 1'b1};
                        d.bits = 4'(q.bits + 4'h1);
                    end
                end
                default:
                    d.phase = SMB_IDLE;
            endcase
        end
    end

    // Link state register; cleared by reset or by a bus timeout.
    always_ff @(posedge scl_clk or posedge lrst)
    begin
        if (lrst)
            q <= '0;
        else
            q <= d;
    end

    assign drv = ((q.phase == SMB_ADDR || q.phase == SMB_WR) && q.bits == 4'h8 && q.ack)
        || (q.phase == SMB_RD && q.bits != 4'h8 && !q.tx[7]);

    always_ff @(negedge scl_clk or posedge lrst)
    begin
        if (lrst)
            oe_q <= 1'b0;
        else
            oe_q <= drv;
    end

    assign sda_oe = oe_q;
    assign start_tog = start_q;
    assign stop_tog = stop_q;
    assign ptr_tog = q.ptr_tog;
    assign dat_tog = q.dat_tog;
    assign rd_tog = q.rd_tog;
    assign ara_tog = q.ara_tog;
    assign ptr_byte = q.ptr;
    assign dat_byte = q.dat;
endmodule

module smb_slave #(
    parameter logic [6:0] DEV_ADDR = smb_pkg::DEV_ADDR_STD,
    parameter int TIMEOUT_CYC = smb_pkg::TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_clk,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    output logic alert_n_out,
    output logic alert_n_oe,
    output logic conv_run,
    output logic conv_oneshot,
    output logic conv_abort,
    input wire logic conv_done,
    input wire logic conv_busy,
    input wire logic [7:0] conv_local,
    input wire logic [7:0] conv_remote,
    input wire logic conv_open
);
    import smb_pkg::*;

    typedef struct packed {
        logic [7:0] sy1;
        logic [7:0] sy2;
        logic [7:0] sy3;
        logic [7:0] ptr;
        logic [7:0] cfg;
        logic [7:0] rate;
        logic [7:0] lhi;
        logic [7:0] llo;
        logic [7:0] rhi;
        logic [7:0] rlo;
        logic [7:0] filt;
        logic [7:0] lval;
        logic [7:0] rval;
        logic [6:0] stat;
        logic open_now;
        logic alert;
        logic busy;
        logic [TOUT_W-1:0] tcnt;
        logic abort;
        logic run;
        logic shot;
        logic shot_act;
        logic stop_conv;
        logic [7:0] rd_word;
    } smb_core_s;

    smb_core_s q, d;
    logic l_start, l_stop, l_ptr, l_dat, l_rd, l_ara;
    logic [7:0] l_ptr_byte, l_dat_byte, ev;
    logic [4:0] trip, fault;
    logic cmp, alert_en, standby;

    // Limit check: high above limit, low at or below limit.
    function automatic logic [1:0] limit_trip(input logic [7:0] v, input logic [7:0] hi,
                                              input logic [7:0] lo);
        limit_trip = {v > hi, v <= lo};
    endfunction

    smb_link #(
        .DEV_ADDR(DEV_ADDR)
    ) u_link (
        .scl_clk(scl_clk),
        .reset(reset),
        .abort(q.abort),
        .sda_in(serial_data_line_in),
        .alert_on(q.alert),
        .rd_word(q.rd_word),
        .sda_oe(serial_data_line_oe),
        .start_tog(l_start),
        .stop_tog(l_stop),
        .ptr_tog(l_ptr),
        .dat_tog(l_dat),
        .rd_tog(l_rd),
        .ara_tog(l_ara),
        .ptr_byte(l_ptr_byte),
        .dat_byte(l_dat_byte)
    );

    // Events from the link are toggles; edges of the second sync stage mark them.
    assign ev = q.sy2 ^ q.sy3;
    assign standby = q.cfg[CFG_STANDBY_BIT];
    assign alert_en = !q.cfg[CFG_MASK_BIT] && !q.cfg[CFG_THERM2_BIT];
    assign fault = {limit_trip(q.lval, q.lhi, q.llo), limit_trip(q.rval, q.rhi, q.rlo),
                    q.open_now};

    // Register file, conversion control, alert and timeout.
    always_comb
    begin
        d = q;
        cmp = 1'b0;
        d.sy1 = {scl_clk, serial_data_line_in, l_start, l_stop, l_ptr, l_dat, l_rd, l_ara};
        d.sy2 = q.sy1;
        d.sy3 = q.sy2;
        // timeout leaves registers untouched
        // A timeout also clears the link's pointer, data, read and alert toggles. Clearing our copies with them
        // keeps that clear from looking like a data write or a status read.
        if (q.abort)
        begin
            d.sy1[SY_PTR:SY_ARA] = 4'h0;
            d.sy2[SY_PTR:SY_ARA] = 4'h0;
            d.sy3[SY_PTR:SY_ARA] = 4'h0;
        end
        d.abort = 1'b0;
        d.shot = 1'b0;
        d.stop_conv = 1'b0;
        // The written words are stable long before their toggle is seen here.
        if (ev[SY_PTR])
            d.ptr = l_ptr_byte;
        if (ev[SY_DAT])
        begin
            case (q.ptr)
                WR_CFG: d.cfg = l_dat_byte;
                WR_RATE: d.rate = l_dat_byte;
                WR_LHI:
                begin
                    d.lhi = l_dat_byte;
                    cmp = 1'b1;
                end
                WR_LLO:
                begin
                    d.llo = l_dat_byte;
                    cmp = 1'b1;
                end
                WR_RHI:
                begin
                    d.rhi = l_dat_byte;
                    cmp = 1'b1;
                end
                WR_RLO:
                begin
                    d.rlo = l_dat_byte;
                    cmp = 1'b1;
                end
                ONE_SHOT_TRIGGER:
                begin
                    if (standby)
                    begin
                        d.shot = 1'b1;
                        d.shot_act = 1'b1;
                    end
                end
                ALERT_FILTER_AND_BUS_TIMEOUT: d.filt = l_dat_byte;
                default: d.filt = q.filt;
            endcase
        end
        d.run = !d.cfg[CFG_STANDBY_BIT];
        if (d.cfg[CFG_STANDBY_BIT] && !standby)
            d.stop_conv = 1'b1;
        if (conv_done && (!standby || q.shot_act))
        begin
            d.lval = conv_local;
            d.rval = conv_remote;
            d.open_now = conv_open;
            d.shot_act = 1'b0;
            cmp = 1'b1;
        end
        trip = {limit_trip(d.lval, d.lhi, d.llo), limit_trip(d.rval, d.rhi, d.rlo), d.open_now};
        // Status clears on a read of its offset; a new trip in that cycle wins.
        if (ev[SY_RD] && q.ptr == RD_STATUS)
            d.stat = 7'h00;
        if (cmp)
            d.stat[6:2] = d.stat[6:2] | trip;
        if (!alert_en)
            d.alert = 1'b0;
        else if (cmp && (|trip))
            d.alert = 1'b1;
        else if (ev[SY_ARA] && !(|fault) && q.stat[6:2] == 5'h00)
            d.alert = 1'b0;
        // Bus activity tracking for the timeout.
        if (ev[SY_START])
            d.busy = 1'b1;
        if (ev[SY_STOP])
            d.busy = 1'b0;
        if (!q.filt[TOUT_EN_BIT] || !q.busy || ev[SY_SCL] || ev[SY_SDA])
            d.tcnt = '0;
        else if (q.tcnt == TOUT_W'(TIMEOUT_CYC - 1))
        begin
            d.abort = 1'b1;
            d.busy = 1'b0;
            d.tcnt = '0;
        end
        else
            d.tcnt = TOUT_W'(q.tcnt + 1'b1);
        case (d.ptr)
            RD_LOCAL: d.rd_word = d.lval;
            RD_REMOTE: d.rd_word = d.rval;
            RD_STATUS: d.rd_word = {conv_busy, d.stat};
            RD_CFG: d.rd_word = d.cfg;
            RD_RATE: d.rd_word = d.rate;
            RD_LHI: d.rd_word = d.lhi;
            RD_LLO: d.rd_word = d.llo;
            RD_RHI: d.rd_word = d.rhi;
            RD_RLO: d.rd_word = d.rlo;
            ALERT_FILTER_AND_BUS_TIMEOUT: d.rd_word = d.filt;
            default: d.rd_word = 8'h00;
        endcase
    end

    // Core state register.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
            q.cfg <= RST_CFG;
            q.rate <= RST_RATE;
            q.lhi <= RST_HI;
            q.llo <= RST_LO;
            q.rhi <= RST_HI;
            q.rlo <= RST_LO;
            q.filt <= RST_FILTER;
            q.run <= 1'b1;
        end
        else
            q <= d;
    end

    // Both open-drain pins only ever pull low.
    assign serial_data_line_out = 1'b0;
    assign alert_n_out = 1'b0;
    assign alert_n_oe = q.alert;
    assign conv_run = q.run;
    assign conv_oneshot = q.shot;
    assign conv_abort = q.stop_conv;
endmodule

// ---- sim/smb_mst.sv ----
`timescale 1ns/10ps
module smb_mst (
    output logic scl_clk,
    output logic pull_low,
    input wire logic data_line
);
    // Between frames the clock stands high and the data line is left to its pull-up.
    initial
    begin
        scl_clk = 1'b1;
        pull_low = 1'b0;
    end

    task automatic start();
        #6 pull_low = 1'b1;
        #6 scl_clk = 1'b0;
    endtask

    task automatic bitx(input logic b, output logic r);
        #1 pull_low = !b;
        #5 scl_clk = 1'b1;
        r = data_line;
        #6 scl_clk = 1'b0;
    endtask

    // nine clocks, master never acknowledges a read byte
    task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(1'b1, r);
        ack = !r;
    endtask

    task automatic stop();
        #1 pull_low = 1'b1;
        #5 scl_clk = 1'b1;
        #6 pull_low = 1'b0;
        #100;
    endtask
endmodule

// ---- sim/smb_slave_props.sv ----
`timescale 1ns/10ps
module smb_slave_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_clk,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    input wire logic alert_n_out,
    input wire logic alert_n_oe,
    input wire logic conv_run,
    input wire logic conv_oneshot,
    input wire logic conv_abort
);
    logic oe_rise_q;
    logic [3:0] hi_cnt_q;

    // Data drive as it stood at the last rising serial clock edge.
    always_ff @(posedge scl_clk or posedge reset)
    begin
        if (reset)
            oe_rise_q <= 1'b0;
        else
            oe_rise_q <= serial_data_line_oe;
    end

    // Core cycles with the serial clock high; it saturates so a long idle never wraps.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hi_cnt_q <= 4'h0;
        else if (!scl_clk)
            hi_cnt_q <= 4'h0;
        else if (hi_cnt_q != 4'hF)
            hi_cnt_q <= hi_cnt_q + 4'h1;
    end

    AST_RESET_STATE: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> !serial_data_line_oe && !alert_n_oe && conv_run)
        else $error("outputs not quiet after reset");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (reset)
        serial_data_line_out == 1'b0 && alert_n_out == 1'b0)
        else $error("open drain output driven high");
    AST_SDA_STEADY: assert property (@(negedge scl_clk) disable iff (reset)
        serial_data_line_oe == oe_rise_q)
        else $error("data drive moved while clock high");
    AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (reset)
        hi_cnt_q >= 4'h4 |-> !serial_data_line_oe)
        else $error("data line held on idle bus");
    AST_ONESHOT_PULSE: assert property (@(posedge clk) disable iff (reset)
        conv_oneshot |=> !conv_oneshot)
        else $error("one-shot strobe longer than one cycle");
    AST_ONESHOT_STANDBY: assert property (@(posedge clk) disable iff (reset)
        conv_oneshot |-> !conv_run)
        else $error("one-shot strobe outside standby");
    AST_ABORT_PULSE: assert property (@(posedge clk) disable iff (reset)
        conv_abort |=> !conv_abort && !conv_run)
        else $error("abort strobe wrong");
    AST_ABORT_WITH_STANDBY: assert property (@(posedge clk) disable iff (reset)
        $fell(conv_run) |-> conv_abort)
        else $error("standby entered without abort");

    // Main scenarios of the bench.
    cover property (@(posedge clk) disable iff (reset) $rose(alert_n_oe));
    cover property (@(posedge clk) disable iff (reset) $fell(alert_n_oe));
    cover property (@(posedge clk) disable iff (reset) conv_oneshot);
    cover property (@(posedge clk) disable iff (reset) conv_abort);
endmodule

bind smb_slave smb_slave_props i_smb_slave_props (
    .clk(clk), .reset(reset), .scl_clk(scl_clk),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
    .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .conv_run(conv_run),
    .conv_oneshot(conv_oneshot), .conv_abort(conv_abort)
);

// ---- sim/smb_slave_test.sv ----
`timescale 1ns/10ps
module smb_slave_test;
    import smb_pkg::*;
    logic clk;
    logic reset = 1'b1;
    logic conv_done = 1'b0;
    logic conv_busy = 1'b0;
    logic [7:0] conv_local = 8'h00;
    logic [7:0] conv_remote = 8'h00;
    wire scl_clk, m_oe, sdl_out, sdl_oe, alert_n_out, alert_n_oe;
    wire conv_run, conv_oneshot, conv_abort, data_line;
    int err_count = 0, checks = 0, cyc = 0, n_shot = 0, n_abort = 0;
    logic [15:0] rv [7] = '{{RD_CFG, RST_CFG}, {RD_RATE, RST_RATE}, {RD_LHI, RST_HI},
        {RD_LLO, RST_LO}, {RD_RHI, RST_HI}, {RD_RLO, RST_LO},
        {ALERT_FILTER_AND_BUS_TIMEOUT, RST_FILTER}};

    // The line is pulled up and low while either party pulls it.
    assign data_line = !(m_oe || (sdl_oe && !sdl_out));

    smb_slave #(.DEV_ADDR(DEV_ADDR_STD), .TIMEOUT_CYC(200)) i_smb_slave (
        .clk(clk), .reset(reset), .scl_clk(scl_clk), .serial_data_line_in(data_line),
        .serial_data_line_out(sdl_out), .serial_data_line_oe(sdl_oe),
        .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .conv_run(conv_run),
        .conv_oneshot(conv_oneshot), .conv_abort(conv_abort), .conv_done(conv_done),
        .conv_busy(conv_busy), .conv_local(conv_local), .conv_remote(conv_remote),
        .conv_open(1'b0)
    );
    smb_mst i_smb_mst (.scl_clk(scl_clk), .pull_low(m_oe), .data_line(data_line));

    // Core clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Counts converter strobes and cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        n_shot += int'(conv_oneshot);
        n_abort += int'(conv_abort);
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    // Pointer byte, then an optional data byte whose acknowledge is not judged.
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
        logic [7:0] q;
        logic a;
        i_smb_mst.start();
        i_smb_mst.xb({DEV_ADDR_STD, 1'b0}, q, a);
        chk(8'(a), 8'h01);
        i_smb_mst.xb(p, q, a);
        chk(8'(a), 8'h01);
        if (n > 1)
            i_smb_mst.xb(d, q, a);
        i_smb_mst.stop();
    endtask

    // A read frame; pull holds bits that a rival device forces low.
    task automatic rd(input logic [6:0] ad, input logic [7:0] pull, output logic [7:0] q,
                      output logic a);
        logic n;
        i_smb_mst.start();
        i_smb_mst.xb({ad, 1'b1}, q, a);
        if (a)
            i_smb_mst.xb(pull, q, n);
        i_smb_mst.stop();
    endtask

    task automatic rreg(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] q;
        logic a;
        wr(p, 8'h00, 1);
        rd(DEV_ADDR_STD, 8'hFF, q, a);
        chk(q, e);
    endtask

    // Stalls a frame with the clock low while the device acknowledges.
    task automatic hang();
        logic [7:0] ad;
        logic r;
        ad = {DEV_ADDR_STD, 1'b0};
        i_smb_mst.start();
        for (int i = 7; i >= 0; i--)
            i_smb_mst.bitx(ad[i], r);
        #20;
    endtask

    task automatic conv(input logic [7:0] l, input logic [7:0] r);
        @(posedge clk);
        conv_local <= l;
        conv_remote <= r;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        logic [7:0] q;
        logic a;
        logic r;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rv[i])
            rreg(rv[i][15:8], rv[i][7:0]);
        rd(ARA_ADDR, 8'hFF, q, a);
        chk(8'(a), 8'h00);
        chk(8'(alert_n_oe), 8'h00);
        done("reset values");
        wr(WR_LHI, 8'h60, 2);
        chk(8'(alert_n_oe), 8'h01);
        rreg(RD_LHI, 8'h60);
        wr(RD_LLO, 8'h33, 2);
        rreg(RD_LLO, RST_LO);
        rd(DEV_ADDR_STD, 8'hFF, q, a);
        chk(q, RST_LO);
        i_smb_mst.start();
        i_smb_mst.xb({DEV_ADDR_STD, 1'b0}, q, a);
        i_smb_mst.xb(WR_LLO, q, a);
        i_smb_mst.xb(8'h01, q, a);
        i_smb_mst.xb(8'h02, q, a);
        i_smb_mst.stop();
        chk(8'(a), 8'h00);
        rreg(RD_LLO, 8'h01);
        rd(DEV_ADDR_ALT, 8'hFF, q, a);
        chk(8'(a), 8'h00);
        done("register access");
        conv(8'h70, 8'h10);
        chk(8'(alert_n_oe), 8'h01);
        conv(8'h20, 8'h10);
        rd(ARA_ADDR, 8'h97, q, a);
        chk(q, 8'h97);
        chk(8'(alert_n_oe), 8'h01);
        rd(ARA_ADDR, 8'hFF, q, a);
        chk(q, {DEV_ADDR_STD, 1'b1});
        chk(8'(alert_n_oe), 8'h01);
        @(posedge clk);
        conv_busy <= 1'b1;
        rreg(RD_STATUS, 8'hE8);
        rd(ARA_ADDR, 8'hFF, q, a);
        chk(8'(alert_n_oe), 8'h00);
        rd(ARA_ADDR, 8'hFF, q, a);
        chk(8'(a), 8'h00);
        done("alert");
        @(posedge clk);
        conv_busy <= 1'b0;
        wr(WR_CFG, 8'h40, 2);
        chk(8'(conv_run), 8'h00);
        chk(8'(n_abort), 8'h01);
        conv(8'h7F, 8'h10);
        rreg(RD_LOCAL, 8'h20);
        wr(ONE_SHOT_TRIGGER, 8'h5A, 2);
        chk(8'(n_shot), 8'h01);
        conv(8'h30, 8'h10);
        chk(8'(conv_run), 8'h00);
        rreg(RD_LOCAL, 8'h30);
        chk(8'(alert_n_oe), 8'h00);
        wr(WR_LHI, 8'h28, 2);
        chk(8'(alert_n_oe), 8'h01);
        done("standby");
        hang();
        repeat (250) @(posedge clk);
        chk(8'(sdl_oe), 8'h01);
        i_smb_mst.bitx(1'b1, r);
        i_smb_mst.stop();
        wr(ALERT_FILTER_AND_BUS_TIMEOUT, 8'h81, 2);
        rreg(ALERT_FILTER_AND_BUS_TIMEOUT, 8'h81);
        hang();
        repeat (150) @(posedge clk);
        chk(8'(sdl_oe), 8'h01);
        repeat (100) @(posedge clk);
        chk(8'(sdl_oe), 8'h00);
        i_smb_mst.stop();
        rreg(RD_CFG, 8'h40);
        rreg(ALERT_FILTER_AND_BUS_TIMEOUT, 8'h81);
        done("timeout");
        summarize();
    end
endmodule
